/* design/usart_sync_slave_sleep_ctrl.sv */
// Synchronous serial port with sleep-time slave operation and APB registers
`include "usart_sync_slave_regs.svh"
`default_nettype none

// Behaviour
// - Only synchronous slave mode keeps shifting in sleep; other modes freeze.
// - Slave shift registers advance only on edges of the external clock pin.
// - Master supplies clock and data in sleep; a complete word sets receive flag.
// - After the shifted word, pending holding byte reloads and transmit flag sets.
// - Writing the holding register clears transmit flag until it empties again.
// - Reading receive data pops the buffer; flag clears when it is empty.
// - Transmit control layout as listed; resets zero except empty status one.
// - In synchronous mode, clock source one means master, zero means slave.
// - Nine-bit transmit selects nine-bit characters, ninth bit from register.
// - Break send marks next asynchronous transmission, cleared by hardware.
// - Asynchronous high speed divides baud clock by 4 if wide, else 16.
// - Empty status reads one while the transmit shift register is empty.
// - In synchronous mode continuous receive, or single receive as master, overrides transmit enable.
// - Receive control layout as listed; all bits reset to zero.
// - Port enable zero holds the port logic in reset.
// - Nine-bit receive selects nine bits; ninth bit shows oldest unread char.
// - Single receive starts one master reception, cleared when it completes.
// - Continuous receive sustains reception and beats single receive.
// - Asynchronous nine-bit address detect accepts only ninth-bit-one characters.
// - Framing error shows the oldest unread character's framing status.
// - Overrun sets on overrun, clears when continuous or port enable clears.
// - Two-character buffer; in continuous receive a third character flags overrun and blocks reception.
module usart_sync_slave_sleep_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor sleep and wake
    input wire logic sleep_mode,
    output logic wake,
    // Clock pin
    input wire logic ck_in,
    output var logic ck_out,
    output logic ck_oe,
    // Data pin
    input wire logic dt_in,
    output var logic dt_out,
    output logic dt_oe,
    // Asynchronous rate
    output var logic [6:0] baud_divisor
);

    // ==========================================
    // Declarations
    usart_sync_slave_pkg::receive_status_control_type rsc_reg;
    usart_sync_slave_pkg::transmit_status_control_type tsc_reg;
    usart_sync_slave_pkg::receive_status_control_type rsc_view;
    usart_sync_slave_pkg::transmit_status_control_type tsc_view;
    usart_sync_slave_pkg::rx_entry_type fifo_mem [0:1];
    usart_sync_slave_pkg::rx_entry_type head_entry;
    usart_sync_slave_pkg::rx_entry_type rx_next;
    usart_sync_slave_pkg::link_mode_type link_mode;
    logic wide_baud_gen_select_reg;
    logic overrun_error_reg;
    logic [1:0] count_reg;
    logic head_reg;
    logic [8:0] rsr_reg;
    logic [8:0] hold_reg;
    logic hold_valid_reg;
    logic [8:0] tsr_reg;
    logic tsr_full_reg;
    logic [3:0] bit_cnt_reg;
    logic ck_prev_reg;
    logic [7:0] div_cnt_reg;
    logic wr, rd;
    logic hit_rdr, hit_thr, hit_rsc, hit_tsc, hit_flg;
    logic wr_thr, rd_rdr;
    logic sync_mode, master, active, run_clock, tick;
    logic lead, trail, last_bit;
    logic rx_done, accept, push, pop, tx_done, load;
    logic receive_complete_flag, transmit_ready_flag;
    logic [3:0] nbits;
    logic [8:0] captured;

    // ==========================================
    // APB decode
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign hit_rdr = paddr == `ADDR_RECEIVE_DATA;
    assign hit_thr = paddr == `ADDR_TRANSMIT_HOLDING;
    assign hit_rsc = paddr == `ADDR_RECEIVE_STATUS_CONTROL;
    assign hit_tsc = paddr == `ADDR_TRANSMIT_STATUS_CONTROL;
    assign hit_flg = paddr == `ADDR_FLAGS_CONFIG;
    assign wr_thr = wr & hit_thr;
    assign rd_rdr = rd & hit_rdr;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_rdr | hit_thr | hit_rsc | hit_tsc | hit_flg);

    // ==========================================
    // Mode selection
    assign sync_mode = tsc_reg.clocked_mode_select;
    assign master = sync_mode & tsc_reg.clock_source_select;
    assign active = rsc_reg.port_enable & sync_mode & (~sleep_mode | ~master);

    always_comb begin
        link_mode = usart_sync_slave_pkg::LINK_IDLE;
        if (sync_mode & (rsc_reg.continuous_receive | (rsc_reg.single_receive & master))) begin
            link_mode = usart_sync_slave_pkg::LINK_RECEIVE;
        end else if (sync_mode & tsc_reg.transmit_enable) begin
            link_mode = usart_sync_slave_pkg::LINK_TRANSMIT;
        end
    end

    // ==========================================
    // Shift clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ck_prev_reg <= 1'b0;
        end else begin
            ck_prev_reg <= ck_in;
        end
    end

    assign run_clock = active & master & (link_mode == usart_sync_slave_pkg::LINK_RECEIVE
        | (link_mode == usart_sync_slave_pkg::LINK_TRANSMIT & tsr_full_reg));
    assign tick = div_cnt_reg == `MASTER_CLK_HALF;

    always_ff @(posedge clk) begin
        if (sys_rst | ~run_clock) begin
            div_cnt_reg <= 8'h00;
            ck_out <= 1'b0;
        end else if (tick) begin
            div_cnt_reg <= 8'h00;
            ck_out <= ~ck_out;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    assign ck_oe = rsc_reg.port_enable & master;

    always_comb begin
        lead = 1'b0;
        trail = 1'b0;
        if (active & master) begin
            lead = tick & ~ck_out & run_clock;
            trail = tick & ck_out & run_clock;
        end else if (active) begin
            lead = ck_in & ~ck_prev_reg;
            trail = ~ck_in & ck_prev_reg;
        end
    end

    // ==========================================
    // Bit counter
    assign nbits = (link_mode == usart_sync_slave_pkg::LINK_RECEIVE)
        ? (rsc_reg.nine_bit_receive ? `CHAR_BITS_9 : `CHAR_BITS_8)
        : (tsc_reg.nine_bit_transmit ? `CHAR_BITS_9 : `CHAR_BITS_8);
    assign last_bit = bit_cnt_reg == nbits - 4'h1;

    always_ff @(posedge clk) begin
        if (sys_rst | ~rsc_reg.port_enable | (link_mode == usart_sync_slave_pkg::LINK_IDLE)) begin
            bit_cnt_reg <= 4'h0;
        end else if (trail & (link_mode == usart_sync_slave_pkg::LINK_RECEIVE | tsr_full_reg)) begin
            bit_cnt_reg <= last_bit ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    // ==========================================
    // Receive path
    assign rx_done = trail & (link_mode == usart_sync_slave_pkg::LINK_RECEIVE) & last_bit;
    assign captured = {dt_in, rsr_reg[8:1]};
    assign accept = sync_mode | ~rsc_reg.nine_bit_receive | ~rsc_reg.address_detect
        | captured[8];
    assign push = rx_done & accept & ~overrun_error_reg & (count_reg != `RX_FIFO_DEPTH);
    assign pop = rd_rdr & (count_reg != 2'h0);

    always_comb begin
        rx_next.framing_error = 1'b0;
        rx_next.ninth = rsc_reg.nine_bit_receive & captured[8];
        rx_next.data = rsc_reg.nine_bit_receive ? captured[7:0] : captured[8:1];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsr_reg <= 9'h000;
        end else if (trail & (link_mode == usart_sync_slave_pkg::LINK_RECEIVE)) begin
            rsr_reg <= captured;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst | ~rsc_reg.port_enable) begin
            count_reg <= 2'h0;
            head_reg <= 1'b0;
        end else begin
            if (push) begin
                fifo_mem[head_reg ^ count_reg[0]] <= rx_next;
            end
            if (pop) begin
                head_reg <= ~head_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    assign head_entry = fifo_mem[head_reg];
    assign receive_complete_flag = count_reg != 2'h0;

    always_ff @(posedge clk) begin
        if (sys_rst | ~rsc_reg.port_enable | ~rsc_reg.continuous_receive) begin
            overrun_error_reg <= 1'b0;
        end else if (rx_done & (count_reg == `RX_FIFO_DEPTH)) begin
            overrun_error_reg <= 1'b1;
        end
    end

    // ==========================================
    // Transmit path
    assign tx_done = trail & (link_mode == usart_sync_slave_pkg::LINK_TRANSMIT)
        & tsr_full_reg & last_bit;
    assign load = active & (link_mode == usart_sync_slave_pkg::LINK_TRANSMIT) & hold_valid_reg
        & (~tsr_full_reg | tx_done);
    assign transmit_ready_flag = ~hold_valid_reg;

    always_ff @(posedge clk) begin
        if (sys_rst | ~rsc_reg.port_enable) begin
            hold_valid_reg <= 1'b0;
            hold_reg <= 9'h000;
        end else if (wr_thr) begin
            hold_valid_reg <= 1'b1;
            hold_reg <= {tsc_reg.ninth_transmit_bit, pwdata[7:0]};
        end else if (load) begin
            hold_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst | ~rsc_reg.port_enable) begin
            tsr_reg <= 9'h000;
            tsr_full_reg <= 1'b0;
            dt_out <= 1'b0;
        end else if (load) begin
            tsr_reg <= hold_reg;
            tsr_full_reg <= 1'b1;
            dt_out <= hold_reg[0];
        end else if (tx_done) begin
            tsr_full_reg <= 1'b0;
        end else if (trail & (link_mode == usart_sync_slave_pkg::LINK_TRANSMIT) & tsr_full_reg) begin
            tsr_reg <= {1'b0, tsr_reg[8:1]};
            dt_out <= tsr_reg[1];
        end
    end

    assign dt_oe = rsc_reg.port_enable & (link_mode == usart_sync_slave_pkg::LINK_TRANSMIT);

    // ==========================================
    // Control registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsc_reg <= `RESET_RECEIVE_STATUS_CONTROL;
        end else if (wr & hit_rsc) begin
            rsc_reg <= pwdata[7:0];
        end else if (rx_done & master) begin
            rsc_reg.single_receive <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tsc_reg <= `RESET_TRANSMIT_STATUS_CONTROL;
            wide_baud_gen_select_reg <= `RESET_FLAGS_CONFIG;
        end else begin
            if (wr & hit_tsc) begin
                tsc_reg <= pwdata[7:0];
            end else if (wr_thr & ~sync_mode) begin
                tsc_reg.break_send <= 1'b0;
            end
            if (wr & hit_flg) begin
                wide_baud_gen_select_reg <= pwdata[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            baud_divisor <= `RATE_DIV_64;
        end else if (tsc_reg.high_baud_select) begin
            baud_divisor <= wide_baud_gen_select_reg ? `RATE_DIV_4 : `RATE_DIV_16;
        end else begin
            baud_divisor <= wide_baud_gen_select_reg ? `RATE_DIV_16 : `RATE_DIV_64;
        end
    end

    // ==========================================
    // Read data
    always_comb begin
        rsc_view = rsc_reg;
        rsc_view.framing_error = receive_complete_flag & head_entry.framing_error;
        rsc_view.overrun_error = overrun_error_reg;
        rsc_view.ninth_received_bit = receive_complete_flag & head_entry.ninth;
        tsc_view = tsc_reg;
        tsc_view.shift_reg_empty = ~tsr_full_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable) begin
            prdata <= 32'h00000000;
            if (hit_rsc) begin
                prdata[7:0] <= rsc_view;
            end else if (hit_tsc) begin
                prdata[7:0] <= tsc_view;
            end else if (hit_rdr & receive_complete_flag) begin
                prdata[7:0] <= head_entry.data;
            end else if (hit_thr) begin
                prdata[7:0] <= hold_reg[7:0];
            end else if (hit_flg) begin
                prdata[2:0] <= {wide_baud_gen_select_reg, transmit_ready_flag,
                    receive_complete_flag};
            end
        end
    end

    assign wake = sleep_mode & (receive_complete_flag
        | (transmit_ready_flag & dt_oe));

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_tx_finish;
        tx_done & hold_valid_reg & ~wr_thr;
    endsequence

    sequence s_reload_seen;
        tsr_full_reg & transmit_ready_flag;
    endsequence

    a_tx_reload_flag: assert property (s_tx_finish |=> s_reload_seen)
        else $error("holding byte not reloaded after shift");
    a_thr_write_clear: assert property (wr_thr & rsc_reg.port_enable
        |=> ~transmit_ready_flag)
        else $error("transmit ready not cleared by write");
    a_rx_pop_clear: assert property (pop & ~push & (count_reg == 2'h1)
        |=> ~receive_complete_flag)
        else $error("receive flag stays after last read");
    a_rx_word_flag: assert property (push |=> receive_complete_flag)
        else $error("receive flag not set after word");
    a_overrun_third: assert property (rx_done & (count_reg == `RX_FIFO_DEPTH)
        & rsc_reg.continuous_receive & rsc_reg.port_enable & ~pop
        |=> overrun_error_reg && count_reg == `RX_FIFO_DEPTH)
        else $error("third character did not flag overrun");
    a_overrun_release: assert property ($fell(rsc_reg.continuous_receive)
        |=> ~overrun_error_reg)
        else $error("overrun not cleared with continuous receive");
    a_sleep_freeze: assert property (sleep_mode & master & $past(sleep_mode)
        |-> ##1 $stable(bit_cnt_reg) || link_mode == usart_sync_slave_pkg::LINK_IDLE)
        else $error("master shifting during sleep");
    a_single_done: assert property (rx_done & master & ~(wr & hit_rsc)
        |=> ~rsc_reg.single_receive)
        else $error("single receive not cleared");
    a_empty_status: assert property (load |=> ~tsc_view.shift_reg_empty ##0 tsr_full_reg)
        else $error("empty status wrong after load");
    a_port_reset: assert property (~rsc_reg.port_enable |=> count_reg == 2'h0
        && ~tsr_full_reg && ~hold_valid_reg)
        else $error("disabled port not held in reset");

endmodule
`default_nettype wire

/* pkg/usart_sync_slave_pkg.sv */
// Types of the synchronous serial port
`default_nettype none
package usart_sync_slave_pkg;

    // ==========================================
    // Register layouts
    typedef struct packed {
        logic port_enable;
        logic nine_bit_receive;
        logic single_receive;
        logic continuous_receive;
        logic address_detect;
        logic framing_error;
        logic overrun_error;
        logic ninth_received_bit;
    } receive_status_control_type;

    typedef struct packed {
        logic clock_source_select;
        logic nine_bit_transmit;
        logic transmit_enable;
        logic clocked_mode_select;
        logic break_send;
        logic high_baud_select;
        logic shift_reg_empty;
        logic ninth_transmit_bit;
    } transmit_status_control_type;

    // ==========================================
    // Receive buffer entry
    typedef struct packed {
        logic framing_error;
        logic ninth;
        logic [7:0] data;
    } rx_entry_type;

    // ==========================================
    // Link operation
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_RECEIVE,
        LINK_TRANSMIT
    } link_mode_type;

endpackage
`default_nettype wire

/* pkg/usart_sync_slave_regs.svh */
// Register addresses, reset values and counts of the synchronous serial port
`ifndef USART_SYNC_SLAVE_REGS_SVH
`define USART_SYNC_SLAVE_REGS_SVH

// ==========================================
// Register indices and APB byte addresses
`define IDX_RECEIVE_DATA 12'h119
`define IDX_TRANSMIT_HOLDING 12'h11A
`define IDX_RECEIVE_STATUS_CONTROL 12'h11D
`define IDX_TRANSMIT_STATUS_CONTROL 12'h11E
`define IDX_FLAGS_CONFIG 12'h120
`define ADDR_RECEIVE_DATA 12'h464
`define ADDR_TRANSMIT_HOLDING 12'h468
`define ADDR_RECEIVE_STATUS_CONTROL 12'h474
`define ADDR_TRANSMIT_STATUS_CONTROL 12'h478
`define ADDR_FLAGS_CONFIG 12'h480

// ==========================================
// Reset values
`define RESET_RECEIVE_STATUS_CONTROL 8'h00
`define RESET_TRANSMIT_STATUS_CONTROL 8'h02
`define RESET_FLAGS_CONFIG 1'b0

// ==========================================
// Counts
`define CHAR_BITS_8 4'h8
`define CHAR_BITS_9 4'h9
`define RX_FIFO_DEPTH 2'h2
`define MASTER_CLK_HALF 8'h19
`define RATE_DIV_4 7'h04
`define RATE_DIV_16 7'h10
`define RATE_DIV_64 7'h40

`endif

/* verif/sync_master_model.sv */
// Model of the external synchronous master on the clock and data pins
`default_nettype none
module sync_master_model (
    // Clock
    input wire logic clk,
    // Pins
    output var logic ck,
    output var logic dt,
    input wire logic dt_line
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ck = 1'b0;
        dt = 1'b0;
    end

    // ==========================================
    // One frame, LSB first, data set on the leading edge
    task automatic xfer(input logic nine, input logic [8:0] tx, output logic [8:0] rx);
        int n;
        n = nine ? 9 : 8;
        rx = 9'h000;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ck <= 1'b1;
            dt <= tx[i];
            repeat (3) @(posedge clk);
            rx[i] = dt_line;
            ck <= 1'b0;
            repeat (2) @(posedge clk);
        end
        // Released data no longer shows the last bit
        @(posedge clk);
        dt <= ~dt;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* verif/tb_usart_sync_slave_sleep_ctrl.sv */
// Self-checking bench of the synchronous serial port
`include "usart_sync_slave_regs.svh"
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_usart_sync_slave_sleep_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_RXD = `ADDR_RECEIVE_DATA;
    localparam logic [11:0] A_TXH = `ADDR_TRANSMIT_HOLDING;
    localparam logic [11:0] A_RSC = `ADDR_RECEIVE_STATUS_CONTROL;
    localparam logic [11:0] A_TSC = `ADDR_TRANSMIT_STATUS_CONTROL;
    localparam logic [11:0] A_FLG = `ADDR_FLAGS_CONFIG;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, perr, sleep_mode = 1'b0, wake, ck_out, ck_oe, dt_out, dt_oe;
    logic mdl_ck, mdl_dt, ck_line, dt_line;
    logic [6:0] baud_divisor;
    logic [8:0] rx;
    int fail_count = 0, compares = 0, cycles = 0;

    assign ck_line = ck_oe ? ck_out : mdl_ck;
    assign dt_line = dt_oe ? dt_out : mdl_dt;
    always #10 clk = ~clk;

    usart_sync_slave_sleep_ctrl usart_sync_slave_sleep_ctrl_i (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .wake(wake), .ck_in(ck_line),
        .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_line), .dt_out(dt_out),
        .dt_oe(dt_oe), .baud_divisor(baud_divisor)
    );
    sync_master_model sync_master_model_i (
        .clk(clk), .ck(mdl_ck), .dt(mdl_dt), .dt_line(dt_line)
    );

    // ==========================================
    // Bus and helpers
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h000000, d});
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input string nm);
        apb(a, 1'b0, 32'h0000_0000);
        `CHK(nm, {24'h000000, e}, rd)
    endtask

    task automatic settle();
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_values();
        rd_chk(A_RSC, 8'h00, "rsc reset");
        rd_chk(A_TSC, 8'h02, "tsc reset");
        rd_chk(A_FLG, 8'h02, "flags reset");
        rd_chk(12'h400, 8'h00, "unmapped read");
        `CHK("unmapped err", 1'b1, perr)
        `CHK("ready", 1'b1, pready)
        `CHK("idle enables", 2'b00, {ck_oe, dt_oe})
    endtask

    task automatic t_sleep_rx();
        wr(A_TSC, 8'h30);
        wr(A_RSC, 8'h90);
        sleep_mode <= 1'b1;
        @(negedge clk);
        `CHK("receive beats transmit", 1'b0, dt_oe)
        `CHK("no wake before word", 1'b0, wake)
        sync_master_model_i.xfer(1'b0, 9'h0A5, rx);
        `CHK("wake in sleep", 1'b1, wake)
        sleep_mode <= 1'b0;
        rd_chk(A_FLG, 8'h03, "rx flag set");
        rd_chk(A_RXD, 8'hA5, "rx data");
        rd_chk(A_FLG, 8'h02, "rx flag clear");
    endtask

    task automatic t_overrun();
        wr(A_RSC, 8'hD0);
        sync_master_model_i.xfer(1'b1, 9'h1A5, rx);
        sync_master_model_i.xfer(1'b1, 9'h03C, rx);
        sync_master_model_i.xfer(1'b1, 9'h0FF, rx);
        rd_chk(A_RSC, 8'hD3, "overrun and ninth");
        rd_chk(A_RXD, 8'hA5, "first kept");
        rd_chk(A_RSC, 8'hD2, "ninth of second");
        rd_chk(A_RXD, 8'h3C, "second kept");
        rd_chk(A_FLG, 8'h02, "third dropped");
        wr(A_RSC, 8'hC0);
        rd_chk(A_RSC, 8'hC0, "overrun cleared");
    endtask

    task automatic t_sleep_tx();
        wr(A_RSC, 8'h80);
        wr(A_TSC, 8'h30);
        wr(A_TXH, 8'h5A);
        wr(A_TXH, 8'hC3);
        rd_chk(A_FLG, 8'h00, "holding full");
        rd_chk(A_TSC, 8'h30, "shift busy");
        sleep_mode <= 1'b1;
        @(negedge clk);
        `CHK("no wake yet", 1'b0, wake)
        sync_master_model_i.xfer(1'b0, 9'h000, rx);
        `CHK("first word", 9'h05A, rx)
        `CHK("reload wakes", 1'b1, wake)
        sleep_mode <= 1'b0;
        sync_master_model_i.xfer(1'b0, 9'h000, rx);
        `CHK("second word", 9'h0C3, rx)
        rd_chk(A_TSC, 8'h32, "shift empty");
        wr(A_TSC, 8'h71);
        wr(A_TXH, 8'h0F);
        sync_master_model_i.xfer(1'b1, 9'h000, rx);
        `CHK("nine bit word", 9'h10F, rx)
    endtask

    task automatic t_master();
        wr(A_TSC, 8'hB0);
        wr(A_RSC, 8'hA0);
        @(negedge clk);
        `CHK("master drives clock", 1'b1, ck_oe)
        repeat (100) @(posedge clk);
        sleep_mode <= 1'b1;
        repeat (100) @(posedge clk);
        `CHK("master clock frozen", 1'b0, ck_out)
        `CHK("no wake while frozen", 1'b0, wake)
        sleep_mode <= 1'b0;
        rd = 32'h0000_0000;
        for (int i = 0; i < 60 && rd[0] !== 1'b1; i++) begin
            repeat (20) @(posedge clk);
            apb(A_FLG, 1'b0, 32'h0000_0000);
        end
        `CHK("master char done", 1'b1, rd[0])
        apb(A_RSC, 1'b0, 32'h0000_0000);
        `CHK("single cleared", 7'h40, rd[7:1])
        wr(A_RSC, 8'h00);
        rd_chk(A_FLG, 8'h02, "disable flushes");
    endtask

    task automatic t_rate();
        wr(A_TSC, 8'h04);
        settle();
        `CHK("high speed", 7'h10, baud_divisor)
        wr(A_FLG, 8'h04);
        settle();
        `CHK("high speed wide", 7'h04, baud_divisor)
        wr(A_TSC, 8'h08);
        rd_chk(A_TSC, 8'h0A, "break armed");
        `CHK("low speed wide", 7'h10, baud_divisor)
        wr(A_TXH, 8'h55);
        apb(A_TSC, 1'b0, 32'h0000_0000);
        `CHK("break cleared", 1'b0, rd[3])
    endtask

    // ==========================================
    // Sequence and hang guard
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_sleep_rx();
        t_overrun();
        t_sleep_tx();
        t_master();
        t_rate();
        tally_and_finish();
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
endmodule
`default_nettype wire
